// ---- cable_mac_header_parser_test.sv ----
`timescale 1ns/1ps
`include "cmhp_regs.vh"
module cable_mac_header_parser_test;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  reg rx_valid = 1'b0;
  reg [7:0] rx_data = 8'h00;
  wire rx_ready, out_valid, out_first, out_last, out_ready;
  wire [7:0] out_data;
  wire [1:0] out_class;
  reg slow = 1'b0;
  reg clr = 1'b0;
  wire [15:0] nb, sum;
  wire [3:0] nf, nl;
  wire [1:0] cls;
  integer errors = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer cnt [0:3];
  reg [31:0] d;
  always #25 clk_sys = ~clk_sys;
  cmhp_parser cmhp_parser_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .out_class(out_class), .out_ready(out_ready));
  cmhp_sink cmhp_sink_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .clr(clr),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .out_class(out_class), .out_ready(out_ready), .nb(nb), .sum(sum), .nf(nf), .nl(nl), .cls(cls));
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, output [31:0] v);
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      v = avs_readdata;
      avs_read <= 1'b0;
    end
  endtask
  task sb(input [7:0] b);
    begin
      rx_data <= b;
      rx_valid <= 1'b1;
      @(posedge clk_sys);
      while (rx_ready !== 1'b1) @(posedge clk_sys);
    end
  endtask
  function [15:0] crc8(input [15:0] c, input [7:0] b);
    integer i;
    begin
      crc8 = c;
      for (i = 7; i >= 0; i = i - 1)
        crc8 = {crc8[14:0], 1'b0} ^ ((crc8[15] ^ b[i]) ? `CMHP_CRC_POLY : 16'h0000);
    end
  endfunction
  // one frame with a leading stuff byte; k picks the counter that should move
  task tst(input [7:0] fc, input [7:0] hp, input [15:0] len, input integer en, input integer pn,
    input integer bad, input integer fwd, input integer k);
    integer i;
    reg [15:0] c;
    reg [15:0] s;
    reg [7:0] b;
    begin
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      sb(`CMHP_STUFF_BYTE);
      c = crc8(crc8(crc8(crc8(`CMHP_CRC_INIT, fc), hp), len[15:8]), len[7:0]);
      sb(fc);
      sb(hp);
      sb(len[15:8]);
      sb(len[7:0]);
      for (i = 0; i < en; i = i + 1) begin
        b = 8'ha0 + i[7:0];
        c = crc8(c, b);
        sb(b);
      end
      c = c ^ {15'h0000, bad[0]};
      sb(c[15:8]);
      sb(c[7:0]);
      s = 16'h0000;
      for (i = 0; i < pn; i = i + 1) begin
        b = 8'h10 + i[7:0];
        s = s + {8'h00, b};
        sb(b);
      end
      rx_valid <= 1'b0;
      repeat (80) @(posedge clk_sys);
      chk(nb, fwd, "bytes");
      chk(sum, fwd ? s : 16'h0000, "sum");
      chk(nf, fwd ? 1 : 0, "first");
      chk(nl, fwd ? 1 : 0, "last");
      if (fwd) chk(cls, fc[7:6], "class");
      if (k < 4) cnt[k] = cnt[k] + 1;
      for (i = 0; i < 4; i = i + 1) begin
        rd(`CMHP_OFS_CNT_ACC + 5'h04 * i[4:0], d);
        chk(d, cnt[i], "counter");
      end
      $display("test done fc %h", fc);
    end
  endtask
  initial begin
    cnt[0] = 0;
    cnt[1] = 0;
    cnt[2] = 0;
    cnt[3] = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`CMHP_OFS_CTRL, d);
    chk(d, {30'h0, `CMHP_CTRL_RESET}, "ctrl");
    rd(5'h1c, d);
    chk(d, 32'h0, "unmapped");
    tst(8'h00, 8'h00, 16'h000e, 0, 14, 0, 14, 0);
    slow <= 1'b1;
    tst(8'h01, 8'h02, 16'h0010, 2, 14, 0, 14, 0);
    tst(8'h01, 8'hf0, 16'h00fc, 240, 12, 0, 12, 0);
    tst(8'h02, 8'h00, 16'h000e, 0, 14, 0, 0, 1);
    tst(8'h00, 8'h03, 16'h000e, 0, 14, 0, 0, 3);
    tst(8'h40, 8'h00, 16'h0005, 0, 5, 0, 0, 1);
    tst(8'h8a, 8'h00, 16'h0007, 0, 7, 0, 0, 1);
    tst(8'h83, 8'h03, 16'h0007, 3, 4, 0, 0, 1);
    tst(8'hc0, 8'h00, 16'h000c, 0, 12, 0, 12, 0);
    tst(8'hc1, 8'h02, 16'h000e, 2, 12, 0, 0, 3);
    tst(8'hc3, 8'h01, 16'h000d, 1, 12, 0, 12, 0);
    tst(8'hc4, 8'h05, 16'h0123, 0, 0, 0, 0, 0);
    tst(8'h00, 8'h00, 16'h000e, 0, 14, 1, 0, 2);
    rd(`CMHP_OFS_STATUS, d);
    chk(d[10:8], `CMHP_V_HCS, "verdict");
    tst(8'h01, 8'h02, 16'h0002, 2, 0, 0, 0, 0);
    wr(`CMHP_OFS_CTRL, 32'h00000003);
    rd(`CMHP_OFS_CTRL, d);
    chk(d, 32'h00000003, "ctrl");
    tst(8'h00, 8'h00, 16'h000b, 0, 11, 0, 0, 3);
    tst(8'h00, 8'h00, 16'h000c, 0, 12, 0, 12, 0);
    rd(`CMHP_OFS_LASTHDR, d);
    chk(d, {16'h000c, 8'h00, 8'h00}, "lasthdr");
    wr(`CMHP_OFS_CNT_ACC, 32'h0);
    cnt[0] = 0;
    wr(`CMHP_OFS_CTRL, 32'h0);
    tst(8'h00, 8'h00, 16'h000e, 0, 14, 0, 0, 4);
    finish_test;
  end
endmodule // cable_mac_header_parser_test

// ---- cmhp_counter.v ----
`timescale 1ns/1ps

module cmhp_counter (
  clk_sys,
  sys_rst,
  clear,
  inc,
  count
);
  input wire clk_sys;
  input wire sys_rst;
  input wire clear;
  input wire inc;
  output reg [31:0] count;

  // increment with clear loads one, so no event is lost
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= 32'h0;
    end else if (inc) begin
      count <= clear ? 32'h1 : count + 32'h1;
    end else if (clear) begin
      count <= 32'h0;
    end
  end
endmodule // cmhp_counter

// ---- cmhp_crc16.v ----
`timescale 1ns/1ps
`include "cmhp_regs.vh"

module cmhp_crc16 (
  clk_sys,
  sys_rst,
  clear,
  en,
  din,
  crc
);
  input wire clk_sys;
  input wire sys_rst;
  input wire clear;
  input wire en;
  input wire [7:0] din;
  output reg [15:0] crc;

  reg [15:0] next_crc;
  reg [15:0] c;
  reg fb;
  integer i;

  // msb-first byte update; clear restarts before this byte
  always @* begin
    c = clear ? `CMHP_CRC_INIT : crc;
    fb = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      fb = c[15] ^ din[7 - i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ `CMHP_CRC_POLY;
      end
    end
    next_crc = c;
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      crc <= `CMHP_CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end else if (clear) begin
      crc <= `CMHP_CRC_INIT;
    end
  end
endmodule // cmhp_crc16

// ---- cmhp_parser.v ----
// Behaviour
// - forward packet PDU whole, CRC kept
// - packet parameter nonzero: ignore frame
// - header parameter zero unless extended header
// - length counts PDU plus extended header
// - extended header at most 240 bytes
// - header check sequence ends each header
// - PDU holds addresses, type, data, CRC
// - suppressed bytes unsent; CRC covers sent
// - upstream packet frame may be empty
// - downstream packet PDU holds both addresses
// - ATM frames discarded, skipped by length
// - reserved PDU frames discarded, skipped
// - reserved length counts payload plus extension
// - specific-header parameter selects header kind
// - timing header carries following timing PDU
// - timing header: no extension, length PDU
// - management header, optional extension, forwarded
// - frame control: type, parameter, extension flag
// - header check is CRC-CCITT over header
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cmhp_regs.vh"

module cmhp_parser (
  clk_sys,
  sys_rst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  rx_valid,
  rx_data,
  rx_ready,
  out_valid,
  out_data,
  out_first,
  out_last,
  out_class,
  out_ready
);
  input wire clk_sys;
  input wire sys_rst;
  input wire [4:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output wire avs_waitrequest;
  input wire rx_valid;
  input wire [7:0] rx_data;
  output wire rx_ready;
  output reg out_valid;
  output reg [7:0] out_data;
  output reg out_first;
  output reg out_last;
  output reg [1:0] out_class;
  input wire out_ready;

  localparam ST_FC = 4'h0;
  localparam ST_PARM = 4'h1;
  localparam ST_LENH = 4'h2;
  localparam ST_LENL = 4'h3;
  localparam ST_EXTENDED_HEADER = 4'h4;
  localparam ST_HCSH = 4'h5;
  localparam ST_HCSL = 4'h6;
  localparam ST_FWD = 4'h7;
  localparam ST_SKIP = 4'h8;

  reg [3:0] state;
  reg [7:0] frame_control_byte;
  reg [7:0] header_param_byte;
  reg [15:0] len_r;
  reg [7:0] extended_header_left;
  reg [7:0] hcs_hi;
  reg [15:0] remain;
  reg first_pending;
  reg [1:0] ctrl;
  reg [2:0] verdict;
  reg bus_ack;

  wire [1:0] frame_type_code = frame_control_byte[`CMHP_FRAME_TYPE_CODE_HI:`CMHP_FRAME_TYPE_CODE_LO];
  wire [4:0] frame_type_param = frame_control_byte[`CMHP_FRAME_TYPE_PARAM_HI:`CMHP_FRAME_TYPE_PARAM_LO];
  wire ext_header_present = frame_control_byte[`CMHP_FC_EXTENDED_HEADER];
  wire enable = ctrl[`CMHP_CTRL_ENABLE];
  wire downstream = ctrl[`CMHP_CTRL_DOWNSTREAM];

  // only the forward state can stall the PHY side
  wire out_free = !out_valid || out_ready;
  assign rx_ready = (state == ST_FWD) ? out_free : 1'b1;
  wire take = rx_valid && rx_ready;

  wire fc_start = (state == ST_FC) && take && enable && (rx_data != `CMHP_STUFF_BYTE);
  wire in_header = (state == ST_PARM) || (state == ST_LENH) || (state == ST_LENL) || (state == ST_EXTENDED_HEADER);
  wire crc_en = fc_start || (in_header && take);
  wire [15:0] crc_val;

  cmhp_crc16 u_crc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(fc_start),
    .en(crc_en),
    .din(rx_data),
    .crc(crc_val)
  );

  // header verdict, evaluated on the second check byte
  wire [7:0] ext_header_length = ext_header_present ? header_param_byte : 8'h00;
  wire [15:0] pdu_len = len_r - {8'h00, ext_header_length};
  wire len_short = len_r < {8'h00, ext_header_length};
  wire hcs_ok = ({hcs_hi, rx_data} == crc_val);
  wire is_packet = (frame_type_code == `CMHP_TYPE_PACKET);
  wire is_spec = (frame_type_code == `CMHP_TYPE_SPECIFIC);
  wire is_timing = is_spec && (frame_type_param == `CMHP_PARM_TIMING);
  wire is_mgmt = is_spec && (frame_type_param == `CMHP_PARM_MGMT);
  wire is_req = is_spec && (frame_type_param == `CMHP_PARM_REQUEST);
  wire is_concat = is_spec && (frame_type_param == `CMHP_PARM_CONCAT);
  wire parm_must_zero = !ext_header_present && (is_packet || is_mgmt ||
    frame_type_code == `CMHP_TYPE_RSVD);
  wire bad_fields = (parm_must_zero && header_param_byte != 8'h00) ||
    (ext_header_present && header_param_byte > `CMHP_EXTENDED_HEADER_MAX) ||
    (is_timing && ext_header_present) ||
    len_short;
  wire pkt_ok = is_packet && (frame_type_param == `CMHP_PARM_PACKET);
  wire ds_short = downstream && pkt_ok && (pdu_len < `CMHP_MIN_DS_PDU);
  wire to_host = pkt_ok || is_timing || is_mgmt;
  wire hdr_done = (state == ST_HCSL) && take;
  wire ev_hcs = hdr_done && !hcs_ok && !is_req;
  wire ev_bad = hdr_done && hcs_ok && !is_req && (bad_fields || ds_short);
  wire ev_disc = hdr_done && hcs_ok && !is_req && !bad_fields && !ds_short && !to_host && !is_concat;
  wire ev_acc = hdr_done && hcs_ok && (is_req || (!bad_fields && !ds_short && (to_host || is_concat)));

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_FC;
      frame_control_byte <= 8'h00;
      header_param_byte <= 8'h00;
      len_r <= 16'h0000;
      extended_header_left <= 8'h00;
      hcs_hi <= 8'h00;
      remain <= 16'h0000;
      first_pending <= 1'b0;
      verdict <= `CMHP_V_ACCEPT;
    end else if (take) begin
      case (state)
        ST_FC: begin
          // stuff bytes and disabled input fall on the floor
          if (fc_start) begin
            frame_control_byte <= rx_data;
            state <= ST_PARM;
          end
        end
        ST_PARM: begin
          header_param_byte <= rx_data;
          state <= ST_LENH;
        end
        ST_LENH: begin
          len_r[15:8] <= rx_data;
          state <= ST_LENL;
        end
        ST_LENL: begin
          len_r[7:0] <= rx_data;
          extended_header_left <= header_param_byte;
          // extended header sits just ahead of the check bytes
          state <= (ext_header_present && header_param_byte != 8'h00) ? ST_EXTENDED_HEADER : ST_HCSH;
        end
        ST_EXTENDED_HEADER: begin
          extended_header_left <= extended_header_left - 8'h01;
          if (extended_header_left == 8'h01) begin
            state <= ST_HCSH;
          end
        end
        ST_HCSH: begin
          hcs_hi <= rx_data;
          state <= ST_HCSL;
        end
        ST_HCSL: begin
          remain <= pdu_len;
          first_pending <= 1'b1;
          if (is_req && hcs_ok) begin
            // length carries a service id, nothing follows
            verdict <= `CMHP_V_REQUEST;
            state <= ST_FC;
          end else if (!hcs_ok) begin
            // skip by the length as received; resync at next header
            verdict <= `CMHP_V_HCS;
            state <= (len_short || pdu_len == 16'h0000 || is_req) ? ST_FC : ST_SKIP;
          end else if (is_concat && !bad_fields) begin
            // inner frames are parsed as ordinary headers
            verdict <= `CMHP_V_ACCEPT;
            state <= ST_FC;
          end else if (ev_acc) begin
            verdict <= `CMHP_V_ACCEPT;
            state <= (pdu_len == 16'h0000) ? ST_FC : ST_FWD;
          end else begin
            verdict <= bad_fields || ds_short ? `CMHP_V_BAD : `CMHP_V_DISCARD;
            state <= (len_short || pdu_len == 16'h0000) ? ST_FC : ST_SKIP;
          end
        end
        ST_FWD: begin
          // bytes pass untouched, trailing CRC included
          first_pending <= 1'b0;
          remain <= remain - 16'h0001;
          if (remain == 16'h0001) begin
            state <= ST_FC;
          end
        end
        ST_SKIP: begin
          remain <= remain - 16'h0001;
          if (remain == 16'h0001) begin
            state <= ST_FC;
          end
        end
        default: begin
          state <= ST_FC;
        end
      endcase
    end
  end

  // output stage: one byte register, stalls the PHY side when full
  wire out_load = take && (state == ST_FWD);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_first <= 1'b0;
      out_last <= 1'b0;
      out_class <= `CMHP_TYPE_PACKET;
    end else if (out_load) begin
      out_valid <= 1'b1;
      out_data <= rx_data;
      out_first <= first_pending;
      out_last <= (remain == 16'h0001);
      out_class <= frame_type_code;
    end else if (out_ready) begin
      // flags qualify only with valid, so they drop with it
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_last <= 1'b0;
    end
  end

  // avalon slave: one wait cycle on every access
  wire bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !bus_ack;
  wire wr_now = avs_write && bus_ack;
  wire [31:0] cnt_acc;
  wire [31:0] cnt_disc;
  wire [31:0] cnt_hcs;
  wire [31:0] cnt_bad;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_ack <= 1'b0;
      ctrl <= `CMHP_CTRL_RESET;
      avs_readdata <= 32'h0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
      if (wr_now && avs_address == `CMHP_OFS_CTRL) begin
        ctrl <= avs_writedata[1:0];
      end
      if (avs_read && !bus_ack) begin
        case (avs_address)
          `CMHP_OFS_CTRL: avs_readdata <= {30'h0, ctrl};
          `CMHP_OFS_STATUS: avs_readdata <= {21'h0, verdict, out_valid, state, 3'h0};
          `CMHP_OFS_LASTHDR: avs_readdata <= {len_r, header_param_byte, frame_control_byte};
          `CMHP_OFS_CNT_ACC: avs_readdata <= cnt_acc;
          `CMHP_OFS_CNT_DISC: avs_readdata <= cnt_disc;
          `CMHP_OFS_CNT_HCS: avs_readdata <= cnt_hcs;
          `CMHP_OFS_CNT_BAD: avs_readdata <= cnt_bad;
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  cmhp_counter u_cnt_acc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(wr_now && avs_address == `CMHP_OFS_CNT_ACC),
    .inc(ev_acc),
    .count(cnt_acc)
  );

  cmhp_counter u_cnt_disc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(wr_now && avs_address == `CMHP_OFS_CNT_DISC),
    .inc(ev_disc),
    .count(cnt_disc)
  );

  cmhp_counter u_cnt_hcs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(wr_now && avs_address == `CMHP_OFS_CNT_HCS),
    .inc(ev_hcs),
    .count(cnt_hcs)
  );

  cmhp_counter u_cnt_bad (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(wr_now && avs_address == `CMHP_OFS_CNT_BAD),
    .inc(ev_bad),
    .count(cnt_bad)
  );
endmodule // cmhp_parser

// ---- cmhp_parser_props.sv ----
`timescale 1ns/1ps
module cmhp_parser_chk (
  input wire clk_sys,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire rx_ready,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_first,
  input wire out_last,
  input wire [1:0] out_class,
  input wire out_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire req;
  assign req = avs_read | avs_write;
  AST_WAIT_ONE: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state not exactly one cycle");
  AST_IDLE_NOWAIT: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("output byte changed while stalled");
  AST_RX_READY: assert property (!out_valid |-> rx_ready)
    else $error("input stalled with empty output");
  AST_FIRST_VALID: assert property (out_first |-> out_valid)
    else $error("first flag without valid");
  AST_LAST_VALID: assert property (out_last |-> out_valid)
    else $error("last flag without valid");
  AST_AFTER_LAST: assert property (out_valid && out_ready && out_last |=> !out_valid || out_first)
    else $error("pdu did not restart after last byte");
  AST_CLASS: assert property (out_valid |-> out_class != 2'h1 && out_class != 2'h2)
    else $error("discarded frame type forwarded");
  AST_REL: assert property ($fell(sys_rst) |-> !out_valid && rx_ready)
    else $error("stream not idle after reset");
  COV_LAST: cover property (out_valid && out_ready && out_last);
  COV_STALL: cover property (out_valid && !out_ready);
  COV_READ: cover property (avs_read && !avs_waitrequest);
endmodule // cmhp_parser_chk

bind cmhp_parser cmhp_parser_chk cmhp_parser_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rx_ready(rx_ready),
  .out_valid(out_valid), .out_data(out_data), .out_first(out_first), .out_last(out_last),
  .out_class(out_class), .out_ready(out_ready));

// ---- cmhp_regs.vh ----
`ifndef CMHP_REGS_VH
`define CMHP_REGS_VH

// register byte offsets
`define CMHP_OFS_CTRL 5'h00
`define CMHP_OFS_STATUS 5'h04
`define CMHP_OFS_LASTHDR 5'h08
`define CMHP_OFS_CNT_ACC 5'h0c
`define CMHP_OFS_CNT_DISC 5'h10
`define CMHP_OFS_CNT_HCS 5'h14
`define CMHP_OFS_CNT_BAD 5'h18

// control fields and reset value
`define CMHP_CTRL_ENABLE 0
`define CMHP_CTRL_DOWNSTREAM 1
`define CMHP_CTRL_RESET 2'h1

// frame control byte layout
`define CMHP_FRAME_TYPE_CODE_HI 7
`define CMHP_FRAME_TYPE_CODE_LO 6
`define CMHP_FRAME_TYPE_PARAM_HI 5
`define CMHP_FRAME_TYPE_PARAM_LO 1
`define CMHP_FC_EXTENDED_HEADER 0

// frame type codes
`define CMHP_TYPE_PACKET 2'h0
`define CMHP_TYPE_ATM 2'h1
`define CMHP_TYPE_RSVD 2'h2
`define CMHP_TYPE_SPECIFIC 2'h3

// type parameters
`define CMHP_PARM_PACKET 5'h00
`define CMHP_PARM_TIMING 5'h00
`define CMHP_PARM_MGMT 5'h01
`define CMHP_PARM_REQUEST 5'h02
`define CMHP_PARM_FRAG 5'h03
`define CMHP_PARM_CONCAT 5'h1c

// limits and constants
`define CMHP_STUFF_BYTE 8'hff
`define CMHP_EXTENDED_HEADER_MAX 8'hf0
`define CMHP_MIN_DS_PDU 16'h000c
`define CMHP_CRC_INIT 16'hffff
`define CMHP_CRC_POLY 16'h1021

// verdict codes kept in status
`define CMHP_V_ACCEPT 3'h0
`define CMHP_V_DISCARD 3'h1
`define CMHP_V_HCS 3'h2
`define CMHP_V_BAD 3'h3
`define CMHP_V_REQUEST 3'h4

`endif

// ---- cmhp_sink.sv ----
`timescale 1ns/1ps
module cmhp_sink (
  input wire clk_sys,
  input wire sys_rst,
  input wire slow,
  input wire clr,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_first,
  input wire out_last,
  input wire [1:0] out_class,
  output reg out_ready,
  output reg [15:0] nb,
  output reg [15:0] sum,
  output reg [3:0] nf,
  output reg [3:0] nl,
  output reg [1:0] cls
);
  always @(posedge clk_sys) begin
    // stall every other cycle when slow, to back up the parser
    out_ready <= slow ? ~out_ready : 1'b1;
    if (sys_rst | clr) begin
      nb <= 16'h0000;
      sum <= 16'h0000;
      nf <= 4'h0;
      nl <= 4'h0;
      cls <= 2'h0;
    end else if (out_valid && out_ready) begin
      nb <= nb + 16'h0001;
      sum <= sum + {8'h00, out_data};
      nf <= nf + {3'h0, out_first};
      nl <= nl + {3'h0, out_last};
      cls <= out_class;
    end
  end
endmodule // cmhp_sink
